// >>> bench/fpes_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fpes_core_asserts #(
    parameter int PROG_CYCLES   = 20,
    parameter int SECTOR_CYCLES = 20,
    parameter int SMALL_CYCLES  = 20,
    parameter int LARGE_CYCLES  = 20,
    parameter int ADDR_W        = 32
) (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               sel_n,
    input wire logic               protect_level_bit0,
    input wire logic               protect_level_bit1,
    input wire logic               protect_level_bit2,
    input wire logic               protect_level_bit3,
    input wire logic               protect_level_bit4,
    input wire logic               page_protected,
    input wire logic               write_latch_flag,
    input wire logic               cycle_in_progress_flag,
    input wire logic [4:0]         protect_level,
    input wire logic [ADDR_W-1:0]  target_addr,
    input wire fpes_pkg::fpes_op_t target_op,
    input wire logic               array_start,
    input wire logic               array_done,
    input wire logic [8:0]         data_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // busy length bookkeeping
    logic [31:0]        busy_q;
    logic [31:0]        want;
    fpes_pkg::fpes_op_t op_q;
    always_ff @(posedge clk) begin
        if (!rst_n) busy_q <= 32'h0;
        else if (cycle_in_progress_flag) busy_q <= busy_q + 32'h1;
        else busy_q <= 32'h0;
    end
    always_ff @(posedge clk) begin
        if (array_start) op_q <= target_op;
    end
    always_comb begin
        case (op_q)
            fpes_pkg::FPES_OP_PROG:   want = PROG_CYCLES;
            fpes_pkg::FPES_OP_SECTOR: want = SECTOR_CYCLES;
            fpes_pkg::FPES_OP_SMALL:  want = SMALL_CYCLES;
            fpes_pkg::FPES_OP_LARGE:  want = LARGE_CYCLES;
            default:                  want = 32'h0;
        endcase
    end
    // ==========================================
    // properties
    sequence cyc_begin;
        $rose(cycle_in_progress_flag);
    endsequence
    sequence cyc_end;
        $fell(cycle_in_progress_flag);
    endsequence
    latch_clear_a: assert property (cyc_begin |-> ##[0:1] !write_latch_flag)
        else $error("latch still set in cycle");
    latch_before_a: assert property (cyc_begin |-> $past(write_latch_flag)
        || $past(write_latch_flag, 2)) else $error("cycle without latch");
    select_high_a: assert property (cyc_begin |-> sel_n && $past(sel_n, 2))
        else $error("cycle before select rose");
    start_pulse_a: assert property (cyc_begin |-> ##[0:2] array_start)
        else $error("no array start");
    cycle_len_a: assert property (cyc_end |-> busy_q == want)
        else $error("wrong cycle length");
    done_pulse_a: assert property (cyc_end |-> array_done || $past(array_done))
        else $error("no array done");
    no_protect_a: assert property (cyc_begin |-> !page_protected)
        else $error("protected target started");
    level_pass_a: assert property (protect_level == {protect_level_bit4,
        protect_level_bit3, protect_level_bit2, protect_level_bit1, protect_level_bit0})
        else $error("protect level differs");
    count_sat_a: assert property (data_count <= 9'h100)
        else $error("data count above page");
    unit_align_a: assert property (array_start |->
        (target_op != fpes_pkg::FPES_OP_SECTOR || target_addr[11:0] == 12'h000)
        && (target_op != fpes_pkg::FPES_OP_SMALL || target_addr[14:0] == 15'h0000)
        && (target_op != fpes_pkg::FPES_OP_LARGE || target_addr[15:0] == 16'h0000))
        else $error("erase address not aligned");
endmodule : fpes_core_asserts
bind fpes_core fpes_core_asserts #(.PROG_CYCLES(PROG_CYCLES), .SECTOR_CYCLES(SECTOR_CYCLES),
    .SMALL_CYCLES(SMALL_CYCLES), .LARGE_CYCLES(LARGE_CYCLES), .ADDR_W(ADDR_W)) u_asserts (
    .clk, .rst_n, .sel_n, .protect_level_bit0, .protect_level_bit1, .protect_level_bit2,
    .protect_level_bit3, .protect_level_bit4, .page_protected, .write_latch_flag,
    .cycle_in_progress_flag, .protect_level, .target_addr, .target_op, .array_start,
    .array_done, .data_count);
`default_nettype wire

// >>> bench/fpes_host.sv
`timescale 1ns/1ps
`default_nettype none
module fpes_host (
    input wire logic  clk,
    output var logic  sel_n,
    output var logic  sclk,
    output var logic [3:0] io
);
    initial begin
        sel_n = 1'b1;
        sclk  = 1'b0;
        io    = 4'h5;
    end
    // released lines toggle so no stale value is read
    always @(negedge clk) begin
        if (sel_n) io <= ~io;
    end
    // ==========================================
    // shifting, msb first, sclk 8 clk period
    task automatic put(input logic [31:0] v, input int n, input bit q);
        for (int i = n - 1; i >= 0; i = i - (q ? 4 : 1)) begin
            @(negedge clk);
            if (q) io <= v[i -: 4];
            else io <= {~io[3:1], v[i]};
            repeat (3) @(negedge clk);
            sclk <= 1'b1;
            repeat (4) @(negedge clk);
            sclk <= 1'b0;
        end
    endtask : put
    task automatic frame(input logic [7:0] c, input logic [31:0] a, input int nab, input int nd,
                         input logic [7:0] d0, input bit q, input int ex);
        @(negedge clk);
        sel_n <= 1'b0;
        put({24'h0, c}, 8, 1'b0);
        put(a, nab * 8, q);
        for (int k = 0; k < nd; k++) put({24'h0, d0 + 8'(k)}, 8, q);
        if (ex > 0) put(32'h0, ex, 1'b0);
        repeat (2) @(negedge clk);
        sel_n <= 1'b1;
    endtask : frame
endmodule : fpes_host
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int PC = 40;
    logic clk, rst_n, sel_n, sclk, qen, fbm, pprot, wac, wlf, cip, ast, adn, bwe;
    logic [3:0]  io;
    logic [4:0]  plb, plv;
    logic [31:0] taddr, a;
    logic [7:0]  bwd, bwa;
    logic [8:0]  dcnt;
    fpes_pkg::fpes_op_t top;
    int miscompares = 0, cmp_count = 0, cyc = 0, sh;
    fpes_pkg::fpes_op_t q_op[$];
    int          q_sh[$];
    logic [31:0] q_ad[$];
    logic [15:0] q_wr[$];
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    fpes_host host (.clk(clk), .sel_n(sel_n), .sclk(sclk), .io(io));
    fpes_core #(.PROG_CYCLES(PC), .SECTOR_CYCLES(60), .SMALL_CYCLES(80), .LARGE_CYCLES(100)) dut (
        .clk(clk), .rst_n(rst_n), .sel_n(sel_n), .sclk(sclk), .quad_line_0(io[0]),
        .quad_line_1(io[1]), .quad_line_2(io[2]), .quad_line_3(io[3]), .quad_io_enable_bit(qen),
        .four_byte_mode(fbm), .protect_level_bit0(plb[0]), .protect_level_bit1(plb[1]),
        .protect_level_bit2(plb[2]), .protect_level_bit3(plb[3]), .protect_level_bit4(plb[4]),
        .page_protected(pprot), .write_allow_command(wac), .write_latch_flag(wlf),
        .cycle_in_progress_flag(cip), .protect_level(plv), .target_addr(taddr),
        .target_op(top), .array_start(ast), .array_done(adn), .buf_wdata(bwd),
        .buf_waddr(bwa), .buf_we(bwe), .data_count(dcnt));
    // ==========================================
    // checking
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task summarize;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (ast === 1'b1 && q_op.size() == 0) chk("start", 32'h0, 32'h1);
        else if (ast === 1'b1) begin
            sh = q_sh.pop_front();
            chk("op", q_op.pop_front(), top);
            chk("addr", q_ad.pop_front() >> sh, taddr >> sh);
        end
        if (bwe === 1'b1 && q_wr.size() > 0) chk("wr", q_wr.pop_front(), {bwa, bwd});
        if (cyc > 40000) begin
            miscompares++;
            summarize();
        end
    end
    // ==========================================
    // stimulus
    task wait_cip(input logic v);
        for (int i = 0; i < 300 && cip !== v; i++) @(negedge clk);
        chk("busy", v, cip);
    endtask : wait_cip
    task run(input logic [7:0] c, input int nab, input int nd, input bit q, input int ex,
             input bit wr, input bit ok, input int op, input int s);
        logic [7:0] d0;
        d0 = 8'($urandom);
        if (wr) begin
            @(negedge clk) wac <= 1'b1;
            @(negedge clk) wac <= 1'b0;
            chk("latch", 32'h1, wlf);
        end
        if (ok) begin
            q_op.push_back(fpes_pkg::fpes_op_t'(3'(op)));
            q_ad.push_back(a);
            q_sh.push_back(s);
            for (int k = 0; k < nd; k++) q_wr.push_back({a[7:0] + 8'(k), d0 + 8'(k)});
        end
        host.frame(c, a, nab, nd, d0, q, ex);
        if (ok && nd > 0) chk("count", (nd > 256) ? 256 : nd, dcnt);
        if (!ok) repeat (12) @(negedge clk);
        wait_cip(ok);
        if (ok) begin
            chk("latch", 32'h0, wlf);
            chk("left", 32'h0, q_wr.size());
            wait_cip(1'b0);
        end
        q_wr.delete();
    endtask : run
    initial begin
        {rst_n, qen, fbm, pprot, wac, plb} = '0;
        a = 32'h0;
        void'($urandom(32'h427950db));
        repeat (20) @(negedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        plb <= 5'($urandom);
        a = {8'h00, 16'($urandom), 8'hF0};
        run(8'h02, 3, 20, 0, 0, 1, 1, 1, 8);
        qen <= 1'b1;
        a = $urandom;
        run(8'h34, 4, 300, 1, 0, 1, 1, 1, 8);
        a = {8'h00, 24'($urandom)};
        run(8'h32, 3, 5, 1, 0, 1, 1, 1, 8);
        for (int i = 0; i < 6; i++) begin
            a = (i % 2) ? $urandom : {8'h00, 24'($urandom)};
            run(8'(i < 2 ? 8'h20 : i < 4 ? 8'h52 : 8'hD8)
                + 8'(i % 2 ? (i < 2 ? 1 : i < 4 ? 10 : 4) : 0),
                (i % 2) ? 4 : 3, 0, 0, 0, 1, 1, 2 + i / 2, i < 2 ? 12 : i < 4 ? 15 : 16);
        end
        fbm <= 1'b1;
        a = $urandom;
        run(8'h20, 4, 0, 0, 0, 1, 1, 2, 12);
        fbm <= 1'b0;
        a = {8'h00, 24'($urandom)};
        run(8'h20, 3, 0, 0, 0, 0, 0, 0, 0);
        run(8'h20, 3, 0, 0, 3, 1, 0, 0, 0);
        run(8'h02, 3, 2, 0, 4, 0, 0, 0, 0);
        qen <= 1'b0;
        run(8'h32, 3, 2, 1, 0, 0, 0, 0, 0);
        pprot <= 1'b1;
        run(8'hD8, 3, 0, 0, 0, 0, 0, 0, 0);
        run(8'h02, 3, 1, 0, 0, 0, 0, 0, 0);
        summarize();
    end
endmodule : tb
`default_nettype wire

// >>> core/fpes_core.sv
`timescale 1ns/1ps
`default_nettype none
module fpes_core #(
    parameter int PROG_CYCLES   = fpes_pkg::PROG_CYCLES,
    parameter int SECTOR_CYCLES = fpes_pkg::SECTOR_CYCLES,
    parameter int SMALL_CYCLES  = fpes_pkg::SMALL_CYCLES,
    parameter int LARGE_CYCLES  = fpes_pkg::LARGE_CYCLES,
    parameter int ADDR_W        = 32
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              sel_n,
    input  wire logic              sclk,
    input  wire logic              quad_line_0,
    input  wire logic              quad_line_1,
    input  wire logic              quad_line_2,
    input  wire logic              quad_line_3,
    input  wire logic              quad_io_enable_bit,
    input  wire logic              four_byte_mode,
    input  wire logic              protect_level_bit0,
    input  wire logic              protect_level_bit1,
    input  wire logic              protect_level_bit2,
    input  wire logic              protect_level_bit3,
    input  wire logic              protect_level_bit4,
    input  wire logic              page_protected,
    input  wire logic              write_allow_command,
    output logic                   write_latch_flag,
    output logic                   cycle_in_progress_flag,
    output logic [4:0]             protect_level,
    output logic [ADDR_W-1:0]      target_addr,
    output fpes_pkg::fpes_op_t     target_op,
    output logic                   array_start,
    output logic                   array_done,
    output logic [7:0]             buf_wdata,
    output logic [7:0]             buf_waddr,
    output logic                   buf_we,
    output logic [8:0]             data_count
);
    // =====================================================
    // pin synchronisers
    logic [5:0] pins_s;
    fpes_sync #(.W(6)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({sel_n, sclk, quad_line_3, quad_line_2, quad_line_1, quad_line_0}),
        .q     (pins_s)
    );
    logic sel_s, sclk_s, sclk_prev_q, sel_prev_q;
    logic [3:0] io_s;
    assign sel_s  = pins_s[5];
    assign sclk_s = pins_s[4];
    assign io_s   = pins_s[3:0];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
            sel_prev_q  <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            sel_prev_q  <= sel_s;
        end
    end
    logic rise, frame_end;
    assign rise      = sclk_s && !sclk_prev_q && !sel_s;
    assign frame_end = sel_s && !sel_prev_q;
    assign protect_level = {protect_level_bit4, protect_level_bit3, protect_level_bit2,
                            protect_level_bit1, protect_level_bit0};

    // =====================================================
    // frame phase tracking
    typedef enum logic [1:0] {FPES_PH_CMD, FPES_PH_ADDR, FPES_PH_DATA, FPES_PH_SKIP} fpes_ph_t;
    fpes_ph_t   ph_q;
    logic [7:0] cmd_q, sh_q;
    logic [3:0] bit_q;
    logic [5:0] abit_q;
    logic       quad_q, four_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] col_q;
    logic       byte_ok_q;
    fpes_pkg::fpes_op_t op_q;

    function automatic fpes_pkg::fpes_op_t decode_op(input logic [7:0] c);
        unique case (c)
            fpes_pkg::CMD_PAGE_WRITE, fpes_pkg::CMD_PAGE_WRITE_4B,
            fpes_pkg::CMD_QUAD_WRITE, fpes_pkg::CMD_QUAD_WRITE_4B: decode_op = fpes_pkg::FPES_OP_PROG;
            fpes_pkg::CMD_SECTOR_CLR, fpes_pkg::CMD_SECTOR_CLR_4B: decode_op = fpes_pkg::FPES_OP_SECTOR;
            fpes_pkg::CMD_SMALL_CLR, fpes_pkg::CMD_SMALL_CLR_4B:   decode_op = fpes_pkg::FPES_OP_SMALL;
            fpes_pkg::CMD_LARGE_CLR, fpes_pkg::CMD_LARGE_CLR_4B:   decode_op = fpes_pkg::FPES_OP_LARGE;
            default: decode_op = fpes_pkg::FPES_OP_NONE;
        endcase
    endfunction : decode_op

    function automatic logic is_4b(input logic [7:0] c);
        is_4b = (c == fpes_pkg::CMD_PAGE_WRITE_4B) || (c == fpes_pkg::CMD_QUAD_WRITE_4B) ||
                (c == fpes_pkg::CMD_SECTOR_CLR_4B) || (c == fpes_pkg::CMD_SMALL_CLR_4B) ||
                (c == fpes_pkg::CMD_LARGE_CLR_4B);
    endfunction : is_4b

    logic [7:0] cmd_next;
    assign cmd_next = {sh_q[6:0], io_s[0]};
    logic [7:0] qbyte_next;
    assign qbyte_next = quad_q ? {sh_q[3:0], io_s} : {sh_q[6:0], io_s[0]};
    logic [3:0] step;
    assign step = quad_q ? 4'd4 : 4'd1;
    logic [5:0] addr_bits;
    assign addr_bits = four_q ? 6'd32 : 6'd24;
    logic       busy;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_q       <= FPES_PH_CMD;
            cmd_q      <= 8'h00;
            sh_q       <= 8'h00;
            bit_q      <= 4'h0;
            abit_q     <= 6'h00;
            quad_q     <= 1'b0;
            four_q     <= 1'b0;
            addr_q     <= '0;
            col_q      <= 8'h00;
            byte_ok_q  <= 1'b0;
            op_q       <= fpes_pkg::FPES_OP_NONE;
            data_count <= 9'h000;
            buf_we     <= 1'b0;
            buf_wdata  <= 8'h00;
            buf_waddr  <= 8'h00;
        end else begin
            buf_we <= 1'b0;
            if (sel_s) begin
                ph_q   <= FPES_PH_CMD;
                bit_q  <= 4'h0;
                sh_q   <= 8'h00;
            end else if (rise) begin
                unique case (ph_q)
                    FPES_PH_CMD: begin
                        sh_q  <= cmd_next;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'd7) begin
                            cmd_q      <= cmd_next;
                            op_q       <= decode_op(cmd_next);
                            quad_q     <= (cmd_next == fpes_pkg::CMD_QUAD_WRITE) ||
                                          (cmd_next == fpes_pkg::CMD_QUAD_WRITE_4B);
                            four_q     <= four_byte_mode || is_4b(cmd_next);
                            abit_q     <= 6'h00;
                            bit_q      <= 4'h0;
                            byte_ok_q  <= 1'b0;
                            data_count <= 9'h000;
                            addr_q     <= '0;
                            ph_q <= (decode_op(cmd_next) == fpes_pkg::FPES_OP_NONE || busy)
                                    ? FPES_PH_SKIP : FPES_PH_ADDR;
                        end
                    end
                    FPES_PH_ADDR: begin
                        // address bits come on the single line; quad uses all four
                        if (quad_q) begin
                            addr_q <= {addr_q[ADDR_W-5:0], io_s};
                            abit_q <= abit_q + 6'd4;
                        end else begin
                            addr_q <= {addr_q[ADDR_W-2:0], io_s[0]};
                            abit_q <= abit_q + 6'd1;
                        end
                        if (abit_q + 6'(step) == addr_bits) begin
                            ph_q      <= FPES_PH_DATA;
                            byte_ok_q <= 1'b1;
                            bit_q     <= 4'h0;
                            col_q     <= quad_q ? {addr_q[3:0], io_s} : {addr_q[6:0], io_s[0]};
                        end
                    end
                    FPES_PH_DATA: begin
                        // an erase frame takes no bits past its address
                        if (op_q != fpes_pkg::FPES_OP_PROG)
                            ph_q <= FPES_PH_SKIP;
                        sh_q      <= qbyte_next;
                        bit_q     <= bit_q + step;
                        byte_ok_q <= 1'b0;
                        if (bit_q + step == 4'd8) begin
                            bit_q     <= 4'h0;
                            byte_ok_q <= 1'b1;
                            if (op_q == fpes_pkg::FPES_OP_PROG) begin
                                buf_we    <= 1'b1;
                                buf_wdata <= qbyte_next;
                                buf_waddr <= col_q;
                                col_q     <= col_q + 8'h01;
                                if (data_count != 9'(fpes_pkg::PAGE_BYTES))
                                    data_count <= data_count + 9'h001;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // =====================================================
    // frame termination and cycle start
    logic valid_end, prot_hit, go;
    always_comb begin
        valid_end = 1'b0;
        if (frame_end && ph_q == FPES_PH_DATA && byte_ok_q && bit_q == 4'h0) begin
            if (op_q == fpes_pkg::FPES_OP_PROG)
                valid_end = data_count != 9'h000 && (!quad_q || quad_io_enable_bit);
            else
                valid_end = data_count == 9'h000 && bit_q == 4'h0 &&
                            !(rise);
        end
    end
    assign prot_hit = page_protected;
    assign go = valid_end && write_latch_flag && !prot_hit && !busy;

    logic [fpes_pkg::CNT_W-1:0] cycles_sel;
    always_comb begin
        unique case (op_q)
            fpes_pkg::FPES_OP_PROG:   cycles_sel = fpes_pkg::CNT_W'(PROG_CYCLES);
            fpes_pkg::FPES_OP_SECTOR: cycles_sel = fpes_pkg::CNT_W'(SECTOR_CYCLES);
            fpes_pkg::FPES_OP_SMALL:  cycles_sel = fpes_pkg::CNT_W'(SMALL_CYCLES);
            fpes_pkg::FPES_OP_LARGE:  cycles_sel = fpes_pkg::CNT_W'(LARGE_CYCLES);
            default:                  cycles_sel = fpes_pkg::CNT_W'(1);
        endcase
    end

    fpes_timer #(.W(fpes_pkg::CNT_W)) u_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .start  (go),
        .cycles (cycles_sel),
        .busy   (busy),
        .done   (array_done)
    );
    assign cycle_in_progress_flag = busy;

    // =====================================================
    // target address, aligned to the erased unit, or to the 256-byte page for a program
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            target_addr <= '0;
            target_op   <= fpes_pkg::FPES_OP_NONE;
            array_start <= 1'b0;
        end else begin
            array_start <= go;
            if (go) begin
                target_op <= op_q;
                unique case (op_q)
                    fpes_pkg::FPES_OP_SECTOR:
                        target_addr <= addr_q & ~ADDR_W'((1 << fpes_pkg::SECTOR_SHIFT) - 1);
                    fpes_pkg::FPES_OP_SMALL:
                        target_addr <= addr_q & ~ADDR_W'((1 << fpes_pkg::SMALL_SHIFT) - 1);
                    fpes_pkg::FPES_OP_LARGE:
                        target_addr <= addr_q & ~ADDR_W'((1 << fpes_pkg::LARGE_SHIFT) - 1);
                    default:
                        target_addr <= {addr_q[ADDR_W-1:8], 8'h00};
                endcase
            end
        end
    end

    // =====================================================
    // write latch flag
    always_ff @(posedge clk) begin
        if (!rst_n)
            write_latch_flag <= 1'b0;
        else if (go)
            write_latch_flag <= 1'b0;
        else if (write_allow_command && !busy)
            write_latch_flag <= 1'b1;
    end
endmodule : fpes_core
`default_nettype wire

// >>> core/fpes_pkg.sv
package fpes_pkg;
    localparam logic [7:0] CMD_WRITE_ALLOW    = 8'h06;
    localparam logic [7:0] CMD_PAGE_WRITE     = 8'h02;
    localparam logic [7:0] CMD_PAGE_WRITE_4B  = 8'h12;
    localparam logic [7:0] CMD_QUAD_WRITE     = 8'h32;
    localparam logic [7:0] CMD_QUAD_WRITE_4B  = 8'h34;
    localparam logic [7:0] CMD_SECTOR_CLR     = 8'h20;
    localparam logic [7:0] CMD_SECTOR_CLR_4B  = 8'h21;
    localparam logic [7:0] CMD_SMALL_CLR      = 8'h52;
    localparam logic [7:0] CMD_SMALL_CLR_4B   = 8'h5C;
    localparam logic [7:0] CMD_LARGE_CLR      = 8'hD8;
    localparam logic [7:0] CMD_LARGE_CLR_4B   = 8'hDC;
    localparam int PAGE_BYTES   = 256;
    localparam int SECTOR_SHIFT = 12;
    localparam int SMALL_SHIFT  = 15;
    localparam int LARGE_SHIFT  = 16;
    localparam int CLK_MHZ      = 50;
    // cycle durations in microseconds, plain defaults
    localparam int PROG_TIME_US        = 200;
    localparam int SECTOR_CLEAR_TIME_US = 1000;
    localparam int SMALL_CLEAR_TIME_US  = 5000;
    localparam int LARGE_CLEAR_TIME_US  = 10000;
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam int SECTOR_CYCLES = SECTOR_CLEAR_TIME_US * CLK_MHZ;
    localparam int SMALL_CYCLES  = SMALL_CLEAR_TIME_US * CLK_MHZ;
    localparam int LARGE_CYCLES  = LARGE_CLEAR_TIME_US * CLK_MHZ;
    localparam int CNT_W = 32;
    typedef enum logic [2:0] {
        FPES_OP_NONE, FPES_OP_PROG, FPES_OP_SECTOR, FPES_OP_SMALL, FPES_OP_LARGE
    } fpes_op_t;
endpackage : fpes_pkg

// >>> core/fpes_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fpes_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : fpes_sync
`default_nettype wire

// >>> core/fpes_timer.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// self-timed cycle counter
module fpes_timer #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic [W-1:0] cycles,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                cnt_q <= cycles;
                busy  <= 1'b1;
            end else if (busy) begin
                if (cnt_q <= W'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_q <= cnt_q - W'(1);
            end
        end
    end
endmodule : fpes_timer
`default_nettype wire
